//--- logic/srlrc_pkg.sv
package srlrc_pkg;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          LFO_PERIOD_NS   = 1000000;
  localparam int          LFO_DIV_DEFAULT = LFO_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          HFO_DIV_DEFAULT = LFO_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          DIV_W           = 17;
  // Bus clock periods in ns for divider codes 00..11 (4, 2, 1, 0.5 MHz)
  localparam int          BUS_NS_0        = 250;
  localparam int          BUS_NS_1        = 500;
  localparam int          BUS_NS_2        = 1000;
  localparam int          BUS_NS_3        = 2000;
  localparam logic [7:0]  BUS_DIV_0       = 8'(BUS_NS_0 / CLK_PERIOD_NS);
  localparam logic [7:0]  BUS_DIV_1       = 8'(BUS_NS_1 / CLK_PERIOD_NS);
  localparam logic [7:0]  BUS_DIV_2       = 8'(BUS_NS_2 / CLK_PERIOD_NS);
  localparam logic [7:0]  BUS_DIV_3       = 8'(BUS_NS_3 / CLK_PERIOD_NS);
  // Register byte addresses
  localparam logic [15:0] TMR_OFF         = 16'h1808;
  localparam logic [15:0] PWR_ONE_OFF     = 16'h1810;
  localparam logic [15:0] PWR_THREE_OFF   = 16'h1814;
  localparam logic [15:0] CAUSE_OFF       = 16'h1818;
  localparam logic [15:0] OPT_OFF         = 16'h181c;
  // periodic_timer_status_control fields
  localparam int          TMR_FLAG_BIT    = 7;
  localparam int          TMR_ACK_BIT     = 6;
  localparam int          TMR_CLKS_BIT    = 5;
  localparam int          TMR_IE_BIT      = 4;
  localparam int          TMR_SEL_LSB     = 0;
  // power_mgmt_ctrl_one fields
  localparam int          WARN_FLAG_BIT   = 7;
  localparam int          WARN_ACK_BIT    = 6;
  localparam int          MON_FLAG_BIT    = 5;
  localparam int          MON_ACK_BIT     = 4;
  localparam int          MON_IE_BIT      = 3;
  localparam int          MON_RE_BIT      = 2;
  localparam int          MON_SE_BIT      = 1;
  localparam int          MON_EN_BIT      = 0;
  // power_mgmt_ctrl_three fields
  localparam int          WARN_SEL_BIT    = 1;
  localparam int          TRIP_SEL_BIT    = 0;
  // reset_cause_register fields
  localparam int          C_POR_BIT       = 7;
  localparam int          C_TEMP_BIT      = 6;
  localparam int          C_WDOG_BIT      = 5;
  localparam int          C_ILOP_BIT      = 4;
  localparam int          C_ILAD_BIT      = 3;
  localparam int          C_WAKE_BIT      = 2;
  localparam int          C_MON_BIT       = 1;
  // system options fields
  localparam int          DIV_SEL_LSB     = 0;
  localparam int          TEMP_EN_BIT     = 2;
  localparam int          KBD_MASK_LSB    = 4;
  // Reset values
  localparam logic [7:0]  CAUSE_POR_RST   = 8'h82;
  localparam logic        MON_EN_RST      = 1'b1;
  localparam logic        MON_RE_RST      = 1'b1;
  // Vector addresses
  localparam logic [15:0] RESET_VEC       = 16'hdffe;
  localparam logic [15:0] SWI_VEC         = 16'hdffc;
  localparam logic [15:0] MON_VEC         = 16'hdff8;
  localparam logic [15:0] TMR_VEC         = 16'hdfe6;
  typedef enum logic [0:0] {SEQ_HOLD, SEQ_RUN} srlrc_seq_type;
  typedef enum logic [1:0] {MODE_RUN, MODE_LIGHT, MODE_DEEP} srlrc_mode_type;
endpackage

//--- logic/srlrc_top.sv
// Notes on behaviour
// R1: All listed reset sources end in one fetch of the top vector entry.
// R2: Software interrupt instruction fetches the entry below reset, unmasked.
// R3: Enabled temperature restart below threshold causes a reset.
// R4: Supply monitor runs only when enabled; trip level picked by select bit.
// R5: Entering any stop mode turns monitor off unless stop enable set.
// R6: Monitor enable plus stop enable refuses deepest stop entry.
// R7: After power-on, reset is held until supply exceeds selected level.
// R8: Power-on sets power-on and supply-monitor cause flags.
// R9: Monitor reset enable and low supply reset, hold, set cause flag.
// R10: Interrupt mode sets monitor flag and raises interrupt, no reset.
// R11: Warning flag sets below level; ack clears only once supply recovers.
// R12: Two-bit divider select picks bus rates 4, 2, 1, 0.5 MHz.
// R13: Every reset clears the bus divider select.
// R14: Four keypad inputs on port pins zero to three wake the part.
// R15: Wake from deepest stop fetches reset vector, not source vector.
// R16: Timer runs from always-on slow oscillator; wakes from all stops.
// R17: Timer flag sets in run or light stop; reset or deep exit clears.
// R18: Writing one to ack clears timer flag; ack reads zero.
// R19: Clock select 0 slow oscillator, 1 fast oscillator in run only.
// R20: Timer interrupt enable gates the flag; reset clears it.
// R21: Period select 000 stops, else 2 to 128 ms; reset clears.
// R22: Enabled timer flag requests the timer vector entry.
// R23: Enabled monitor flag requests the low-supply vector entry.
// R24: Timer count restarts after each timeout and on period change.
`timescale 1ns/1ns
`default_nettype none
module srlrc_top #(
  parameter int LFO_DIV = srlrc_pkg::LFO_DIV_DEFAULT,
  parameter int HFO_DIV = srlrc_pkg::HFO_DIV_DEFAULT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        por_event,
  input  wire logic        supply_below_high,
  input  wire logic        supply_below_low,
  input  wire logic        warn_below_high,
  input  wire logic        warn_below_low,
  input  wire logic        watchdog_timeout,
  input  wire logic        wakeup_reset_event,
  input  wire logic        illegal_opcode,
  input  wire logic        illegal_address,
  input  wire logic        temp_below_restart,
  input  wire logic        swi_executed,
  input  wire logic        stop_enter,
  input  wire logic        stop_deep,
  input  wire logic [3:0]  keypad_wake_input,
  output logic             system_reset,
  output logic             vector_fetch,
  output logic      [15:0] vector_addr,
  output logic             irq_request,
  output logic      [15:0] irq_vector,
  output logic             run_mode,
  output logic             light_stop_mode,
  output logic             deepest_stop_mode,
  output logic             stop_refused,
  output logic             supply_monitor_active,
  output logic             bus_clock_enable,
  output logic      [1:0]  bus_clock_divider_select
);
  typedef struct packed {
    srlrc_pkg::srlrc_seq_type  seq;
    srlrc_pkg::srlrc_mode_type mode;
    logic                      hold_supply;
    logic                      pready;
    logic                      pslverr;
    logic [7:0]                prdata;
    logic                      sys_reset;
    logic                      vec_fetch;
    logic [15:0]               vec_addr;
    logic                      irq_req;
    logic [15:0]               irq_vec;
    logic                      m_run;
    logic                      m_light;
    logic                      m_deep;
    logic                      refused;
    logic                      mon_active;
    logic                      bus_en;
    logic [7:0]                bus_cnt;
    logic [srlrc_pkg::DIV_W-1:0] lfo_cnt;
    logic [srlrc_pkg::DIV_W-1:0] hfo_cnt;
    logic                      lfo_tick;
    logic                      hfo_tick;
    logic [7:0]                tmr_cnt;
    logic                      tmr_flag;
    logic                      tmr_clks;
    logic                      tmr_ie;
    logic [2:0]                tmr_sel;
    logic                      mon_en;
    logic                      mon_se;
    logic                      mon_re;
    logic                      mon_ie;
    logic                      mon_flag;
    logic                      warn_flag;
    logic                      trip_sel;
    logic                      warn_sel;
    logic [7:0]                cause;
    logic [1:0]                div_sel;
    logic                      temp_en;
    logic [3:0]                kbd_mask;
  } srlrc_state_type;

  srlrc_state_type st;
  srlrc_state_type next_st;

  function automatic logic [7:0] bus_div(input logic [1:0] sel);
    unique case (sel)
      2'h0: bus_div = srlrc_pkg::BUS_DIV_0;
      2'h1: bus_div = srlrc_pkg::BUS_DIV_1;
      2'h2: bus_div = srlrc_pkg::BUS_DIV_2;
      2'h3: bus_div = srlrc_pkg::BUS_DIV_3;
    endcase
  endfunction

  function automatic logic reg_hit(input logic [15:0] a,
                                   input logic [15:0] off);
    reg_hit = (a == off);
  endfunction

  logic       low_trip;
  logic       low_warn;
  logic       mon_live;
  logic       mon_rst;
  logic       mon_irq;
  logic       tmr_tick;
  logic       tmr_out;
  logic       wr_go;
  logic       kbd_wake;
  logic       deep_wake;
  logic       any_rst;
  logic       tmr_pend;
  logic       mon_pend;
  logic [7:0] rst_vec;
  logic [7:0] rdv;

  always_comb begin
    next_st = st;
    rdv = 8'h00;
    next_st.vec_fetch = 1'b0;
    next_st.refused = 1'b0;
    next_st.bus_en = 1'b0;
    next_st.lfo_tick = 1'b0;
    next_st.hfo_tick = 1'b0;
    low_trip = st.trip_sel ? supply_below_high : supply_below_low; // [R4]
    low_warn = st.warn_sel ? warn_below_high : warn_below_low; // [R11]
    // Monitor drops out in stop unless told to stay awake
    mon_live = st.mon_en && (st.mode == srlrc_pkg::MODE_RUN || st.mon_se);
    // Gated in hold: a reload there would wipe the power-on cause
    mon_rst = mon_live && st.mon_re && low_trip &&
              st.seq == srlrc_pkg::SEQ_RUN; // [R9]
    mon_irq = mon_live && st.mon_ie && !st.mon_re && low_trip; // [R10]
    // Fast source only counts in run mode
    tmr_tick = st.tmr_clks ? (st.hfo_tick && st.mode == srlrc_pkg::MODE_RUN)
                           : st.lfo_tick; // [R19] [R16]
    tmr_out = tmr_tick && (st.tmr_sel != 3'h0) &&
              (st.tmr_cnt == 8'((9'h001 << st.tmr_sel) - 9'h001)); // [R21]
    wr_go = psel && penable && st.pready && pwrite && pstrb[0];
    kbd_wake = |(st.kbd_mask & keypad_wake_input); // [R14]
    deep_wake = (st.mode == srlrc_pkg::MODE_DEEP) &&
                (kbd_wake || tmr_out || wakeup_reset_event); // [R15]
    rst_vec = 8'h00;
    rst_vec[srlrc_pkg::C_POR_BIT] = por_event;
    rst_vec[srlrc_pkg::C_TEMP_BIT] = st.temp_en && temp_below_restart; // [R3]
    rst_vec[srlrc_pkg::C_WDOG_BIT] = watchdog_timeout;
    rst_vec[srlrc_pkg::C_ILOP_BIT] = illegal_opcode;
    rst_vec[srlrc_pkg::C_ILAD_BIT] = illegal_address;
    rst_vec[srlrc_pkg::C_WAKE_BIT] = wakeup_reset_event;
    rst_vec[srlrc_pkg::C_MON_BIT] = mon_rst || por_event; // [R8] [R9]
    any_rst = (|rst_vec) || deep_wake; // [R1]
    tmr_pend = st.tmr_flag && st.tmr_ie; // [R20]
    mon_pend = st.mon_flag && st.mon_ie;

    // Oscillator and bus clock dividers
    if (st.lfo_cnt == srlrc_pkg::DIV_W'(LFO_DIV - 1)) begin
      next_st.lfo_cnt = '0;
      next_st.lfo_tick = 1'b1;
    end else begin
      next_st.lfo_cnt = st.lfo_cnt + 1'b1;
    end
    if (st.hfo_cnt == srlrc_pkg::DIV_W'(HFO_DIV - 1)) begin
      next_st.hfo_cnt = '0;
      next_st.hfo_tick = 1'b1;
    end else begin
      next_st.hfo_cnt = st.hfo_cnt + 1'b1;
    end
    if (st.bus_cnt >= bus_div(st.div_sel) - 8'h01) begin // [R12]
      next_st.bus_cnt = 8'h00;
      next_st.bus_en = 1'b1;
    end else begin
      next_st.bus_cnt = st.bus_cnt + 8'h01;
    end

    // Register reads, no wait states
    if (reg_hit(paddr, srlrc_pkg::TMR_OFF)) begin
      rdv[srlrc_pkg::TMR_FLAG_BIT] = st.tmr_flag; // [R18]
      rdv[srlrc_pkg::TMR_CLKS_BIT] = st.tmr_clks;
      rdv[srlrc_pkg::TMR_IE_BIT] = st.tmr_ie;
      rdv[srlrc_pkg::TMR_SEL_LSB +: 3] = st.tmr_sel;
    end else if (reg_hit(paddr, srlrc_pkg::PWR_ONE_OFF)) begin
      rdv[srlrc_pkg::WARN_FLAG_BIT] = st.warn_flag;
      rdv[srlrc_pkg::MON_FLAG_BIT] = st.mon_flag;
      rdv[srlrc_pkg::MON_IE_BIT] = st.mon_ie;
      rdv[srlrc_pkg::MON_RE_BIT] = st.mon_re;
      rdv[srlrc_pkg::MON_SE_BIT] = st.mon_se;
      rdv[srlrc_pkg::MON_EN_BIT] = st.mon_en;
    end else if (reg_hit(paddr, srlrc_pkg::PWR_THREE_OFF)) begin
      rdv[srlrc_pkg::WARN_SEL_BIT] = st.warn_sel;
      rdv[srlrc_pkg::TRIP_SEL_BIT] = st.trip_sel;
    end else if (reg_hit(paddr, srlrc_pkg::CAUSE_OFF)) begin
      rdv = st.cause;
    end else if (reg_hit(paddr, srlrc_pkg::OPT_OFF)) begin
      rdv[srlrc_pkg::DIV_SEL_LSB +: 2] = st.div_sel;
      rdv[srlrc_pkg::TEMP_EN_BIT] = st.temp_en;
      rdv[srlrc_pkg::KBD_MASK_LSB +: 4] = st.kbd_mask;
    end
    if (psel && !penable) begin
      next_st.pready = 1'b1;
      next_st.prdata = rdv;
      next_st.pslverr = !(reg_hit(paddr, srlrc_pkg::TMR_OFF) ||
                          reg_hit(paddr, srlrc_pkg::PWR_ONE_OFF) ||
                          reg_hit(paddr, srlrc_pkg::PWR_THREE_OFF) ||
                          reg_hit(paddr, srlrc_pkg::CAUSE_OFF) ||
                          reg_hit(paddr, srlrc_pkg::OPT_OFF));
    end else if (psel && penable && st.pready) begin
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
    end

    // Register writes; a set in the same cycle beats the clear
    if (wr_go && reg_hit(paddr, srlrc_pkg::TMR_OFF)) begin
      if (pwdata[srlrc_pkg::TMR_ACK_BIT]) begin
        next_st.tmr_flag = 1'b0; // [R18]
      end
      next_st.tmr_clks = pwdata[srlrc_pkg::TMR_CLKS_BIT];
      next_st.tmr_ie = pwdata[srlrc_pkg::TMR_IE_BIT];
      next_st.tmr_sel = pwdata[srlrc_pkg::TMR_SEL_LSB +: 3];
      if (pwdata[srlrc_pkg::TMR_SEL_LSB +: 3] != st.tmr_sel) begin
        next_st.tmr_cnt = 8'h00; // [R24]
      end
    end
    if (wr_go && reg_hit(paddr, srlrc_pkg::PWR_ONE_OFF)) begin
      if (pwdata[srlrc_pkg::WARN_ACK_BIT] && !low_warn) begin
        next_st.warn_flag = 1'b0; // [R11]
      end
      if (pwdata[srlrc_pkg::MON_ACK_BIT]) begin
        next_st.mon_flag = 1'b0;
      end
      next_st.mon_ie = pwdata[srlrc_pkg::MON_IE_BIT];
      next_st.mon_re = pwdata[srlrc_pkg::MON_RE_BIT];
      next_st.mon_se = pwdata[srlrc_pkg::MON_SE_BIT];
      next_st.mon_en = pwdata[srlrc_pkg::MON_EN_BIT];
    end
    if (wr_go && reg_hit(paddr, srlrc_pkg::PWR_THREE_OFF)) begin
      next_st.warn_sel = pwdata[srlrc_pkg::WARN_SEL_BIT];
      next_st.trip_sel = pwdata[srlrc_pkg::TRIP_SEL_BIT];
    end
    if (wr_go && reg_hit(paddr, srlrc_pkg::OPT_OFF)) begin
      next_st.div_sel = pwdata[srlrc_pkg::DIV_SEL_LSB +: 2];
      next_st.temp_en = pwdata[srlrc_pkg::TEMP_EN_BIT];
      next_st.kbd_mask = pwdata[srlrc_pkg::KBD_MASK_LSB +: 4];
    end

    // Periodic timer
    if (tmr_out) begin
      next_st.tmr_cnt = 8'h00; // [R24]
      if (st.mode != srlrc_pkg::MODE_DEEP) begin
        next_st.tmr_flag = 1'b1; // [R17]
      end
    end else if (tmr_tick && st.tmr_sel != 3'h0 &&
                 !(wr_go && reg_hit(paddr, srlrc_pkg::TMR_OFF))) begin
      next_st.tmr_cnt = st.tmr_cnt + 8'h01;
    end
    if (mon_irq) begin
      next_st.mon_flag = 1'b1; // [R10]
    end
    if (low_warn) begin
      next_st.warn_flag = 1'b1; // [R11]
    end

    // Power modes
    unique case (st.mode)
      srlrc_pkg::MODE_RUN: begin
        if (stop_enter && st.seq == srlrc_pkg::SEQ_RUN) begin
          if (stop_deep && st.mon_en && st.mon_se) begin
            next_st.refused = 1'b1; // [R6]
          end else if (stop_deep) begin
            next_st.mode = srlrc_pkg::MODE_DEEP;
          end else begin
            next_st.mode = srlrc_pkg::MODE_LIGHT;
          end
        end
      end
      srlrc_pkg::MODE_LIGHT: begin
        if (kbd_wake || tmr_out || tmr_pend || mon_pend) begin
          next_st.mode = srlrc_pkg::MODE_RUN; // [R14] [R16]
        end
      end
      srlrc_pkg::MODE_DEEP: begin
      end
      default: next_st.mode = srlrc_pkg::MODE_RUN;
    endcase

    // Reset sequencing and vector fetch
    if (any_rst) begin
      next_st.seq = srlrc_pkg::SEQ_HOLD;
      next_st.mode = srlrc_pkg::MODE_RUN;
      next_st.hold_supply = por_event || mon_rst; // [R7] [R9]
      next_st.cause = rst_vec; // [R8]
      next_st.div_sel = 2'h0; // [R13]
      next_st.tmr_flag = 1'b0; // [R17]
      next_st.tmr_ie = 1'b0; // [R20]
      next_st.tmr_sel = 3'h0; // [R21]
      next_st.tmr_clks = 1'b0;
      next_st.tmr_cnt = 8'h00;
      next_st.mon_flag = 1'b0;
      next_st.temp_en = 1'b0;
      next_st.kbd_mask = 4'h0;
    end else if (st.seq == srlrc_pkg::SEQ_HOLD) begin
      if (!st.hold_supply || !low_trip) begin
        next_st.seq = srlrc_pkg::SEQ_RUN;
        next_st.vec_fetch = 1'b1;
        next_st.vec_addr = srlrc_pkg::RESET_VEC; // [R1] [R15]
      end
    end else if (swi_executed) begin
      next_st.vec_fetch = 1'b1;
      next_st.vec_addr = srlrc_pkg::SWI_VEC; // [R2]
    end
    next_st.sys_reset = (next_st.seq == srlrc_pkg::SEQ_HOLD);
    // Low supply outranks the timer
    next_st.irq_req = (next_st.seq == srlrc_pkg::SEQ_RUN) &&
                      ((next_st.tmr_flag && next_st.tmr_ie) ||
                       (next_st.mon_flag && next_st.mon_ie));
    next_st.irq_vec = (next_st.mon_flag && next_st.mon_ie) ?
                      srlrc_pkg::MON_VEC : srlrc_pkg::TMR_VEC; // [R22] [R23]
    next_st.m_run = (next_st.mode == srlrc_pkg::MODE_RUN);
    next_st.m_light = (next_st.mode == srlrc_pkg::MODE_LIGHT);
    next_st.m_deep = (next_st.mode == srlrc_pkg::MODE_DEEP);
    next_st.mon_active = next_st.mon_en &&
                         (next_st.m_run || next_st.mon_se); // [R5]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.seq <= srlrc_pkg::SEQ_HOLD;
      st.mode <= srlrc_pkg::MODE_RUN;
      st.hold_supply <= 1'b1;
      st.sys_reset <= 1'b1;
      st.m_run <= 1'b1;
      st.mon_en <= srlrc_pkg::MON_EN_RST;
      st.mon_re <= srlrc_pkg::MON_RE_RST;
      st.mon_active <= srlrc_pkg::MON_EN_RST;
      st.cause <= srlrc_pkg::CAUSE_POR_RST;
      st.irq_vec <= srlrc_pkg::TMR_VEC;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = {24'h000000, st.prdata};
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign system_reset = st.sys_reset;
  assign vector_fetch = st.vec_fetch;
  assign vector_addr = st.vec_addr;
  assign irq_request = st.irq_req;
  assign irq_vector = st.irq_vec;
  assign run_mode = st.m_run;
  assign light_stop_mode = st.m_light;
  assign deepest_stop_mode = st.m_deep;
  assign stop_refused = st.refused;
  assign supply_monitor_active = st.mon_active;
  assign bus_clock_enable = st.bus_en;
  assign bus_clock_divider_select = st.div_sel;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_reset_vector_fetch: assert property ( // [R1]
    $fell(system_reset) |-> vector_fetch &&
      vector_addr == srlrc_pkg::RESET_VEC)
    else $error("reset release without reset vector");
  a_swi_vector_fetch: assert property ( // [R2]
    swi_executed && !system_reset && !any_rst |=>
      vector_fetch && vector_addr == srlrc_pkg::SWI_VEC)
    else $error("software interrupt vector missing");
  a_temp_restart_reset: assert property ( // [R3]
    temp_below_restart && st.temp_en |=> system_reset)
    else $error("temperature restart gave no reset");
  a_stop_monitor_off: assert property ( // [R5]
    !run_mode && !st.mon_se |-> !supply_monitor_active)
    else $error("monitor active in stop without stop enable");
  a_deep_stop_refused: assert property ( // [R6]
    stop_enter && stop_deep && st.mon_en && st.mon_se && run_mode &&
      !system_reset && !any_rst |=> stop_refused && !deepest_stop_mode)
    else $error("deepest stop entered with monitor held on");
  a_supply_hold_reset: assert property ( // [R7]
    system_reset && st.hold_supply && low_trip && !any_rst |=>
      system_reset)
    else $error("reset released while supply low");
  a_monitor_reset_cause: assert property ( // [R9]
    mon_rst |=> system_reset && st.cause[srlrc_pkg::C_MON_BIT])
    else $error("monitor reset or its cause flag missing");
  a_warn_flag_hold: assert property ( // [R11]
    st.warn_flag && low_warn |=> st.warn_flag)
    else $error("warning flag cleared while supply low");
  a_divider_cleared: assert property ( // [R13]
    $rose(system_reset) |-> bus_clock_divider_select == 2'h0)
    else $error("divider select survived reset");
  a_timer_ack_clear: assert property ( // [R18]
    wr_go && reg_hit(paddr, srlrc_pkg::TMR_OFF) &&
      pwdata[srlrc_pkg::TMR_ACK_BIT] && !tmr_out && !any_rst
      |=> !st.tmr_flag)
    else $error("timer flag not acknowledged");
  a_irq_gated: assert property ( // [R20]
    irq_request |-> st.tmr_flag && st.tmr_ie || st.mon_flag && st.mon_ie)
    else $error("interrupt request without enabled flag");

  c_swi_fetch: cover property (vector_fetch &&
    vector_addr == srlrc_pkg::SWI_VEC);
  c_deep_refused: cover property (stop_refused);
  c_light_wake: cover property (light_stop_mode ##1 run_mode);
  c_timer_flag: cover property ($rose(st.tmr_flag));
endmodule
`default_nettype wire

//--- tb/srlrc_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module srlrc_core_model (
  input  wire logic        pclk,
  input  wire logic        system_reset,
  input  wire logic        vector_fetch,
  input  wire logic [15:0] vector_addr,
  output logic      [15:0] last_vector,
  output logic      [7:0]  fetch_count
);
  initial begin
    last_vector = 16'h0000;
    fetch_count = 8'h00;
  end
  // Core only leaves reset or enters a handler through a fetch
  always @(posedge pclk) begin
    if (vector_fetch && !system_reset) begin
      last_vector <= vector_addr;
      fetch_count <= fetch_count + 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- tb/system_reset_lvd_rti_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module system_reset_lvd_rti_control_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr, vector_addr, irq_vector;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb, src, keypad_wake_input;
  logic [7:0]  fetch_count;
  logic [1:0]  bus_clock_divider_select;
  logic        por_event, supply_below_high, supply_below_low, serr;
  logic        warn_below_high, warn_below_low, temp_below_restart;
  logic        swi_executed, stop_enter, stop_deep, system_reset;
  logic        vector_fetch, irq_request, run_mode, light_stop_mode;
  logic        deepest_stop_mode, stop_refused, supply_monitor_active;
  logic        bus_clock_enable;
  int          failures, comparisons, n;
  int          cb[4] = '{srlrc_pkg::C_WDOG_BIT, srlrc_pkg::C_WAKE_BIT,
                         srlrc_pkg::C_ILOP_BIT, srlrc_pkg::C_ILAD_BIT};
  srlrc_top #(.LFO_DIV(4), .HFO_DIV(4)) srlrc_top_i (.*,
    .watchdog_timeout(src[0]), .wakeup_reset_event(src[1]),
    .illegal_opcode(src[2]), .illegal_address(src[3]));
  srlrc_core_model srlrc_core_model_i (.pclk(pclk),
    .system_reset(system_reset), .vector_fetch(vector_fetch),
    .vector_addr(vector_addr), .last_vector(), .fetch_count(fetch_count));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic check(input string what, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) failures++;
    r = prdata; serr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim) begin @(posedge pclk); n++; end
  endtask
  task automatic complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    complete_run;
  end
  initial begin
    {psel, penable, pwrite, por_event, supply_below_high, swi_executed} = '0;
    {warn_below_high, warn_below_low, temp_below_restart, stop_enter} = '0;
    {paddr, pwdata, src, keypad_wake_input, stop_deep} = '0;
    pstrb = 4'hf; presetn = 1'b0; supply_below_low = 1'b1;
    failures = 0; comparisons = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    check("held for supply", system_reset, 1'b1);
    supply_below_low <= 1'b0;
    wait_hi(vector_fetch, 10);
    check("por vector", vector_addr, srlrc_pkg::RESET_VEC);
    apb(0, srlrc_pkg::CAUSE_OFF, 0); check("por cause", r, 8'h82);
    apb(0, srlrc_pkg::TMR_OFF, 0); check("timer reset", r, 8'h00);
    apb(0, 16'h1900, 0); check("unmapped", serr, 1'b1);
    for (int d = 0; d < 4; d++) begin
      apb(1, srlrc_pkg::OPT_OFF, 8'(d));
      repeat (2) begin wait_hi(bus_clock_enable, 300); @(posedge pclk); end
      wait_hi(bus_clock_enable, 300);
      check("bus period", n + 1, 25 << d);
    end
    apb(1, srlrc_pkg::TMR_OFF, 8'h11);
    wait_hi(irq_request, 30);
    check("timer delay", n >= 6 && n <= 11, 1'b1);
    check("timer vector", irq_vector, srlrc_pkg::TMR_VEC);
    apb(0, srlrc_pkg::TMR_OFF, 0); check("timer flag", r, 8'h91);
    apb(1, srlrc_pkg::TMR_OFF, 8'h50);
    apb(0, srlrc_pkg::TMR_OFF, 0); check("timer ack", r, 8'h10);
    for (int i = 0; i < 4; i++) begin
      apb(1, srlrc_pkg::OPT_OFF, 8'h03);
      src[i] <= 1'b1; @(posedge pclk); src[i] <= 1'b0;
      wait_hi(vector_fetch, 10);
      check("reset vector", vector_addr, srlrc_pkg::RESET_VEC);
      apb(0, srlrc_pkg::CAUSE_OFF, 0); check("cause", r, 1 << cb[i]);
      apb(0, srlrc_pkg::OPT_OFF, 0); check("divider", r, 0);
      apb(0, srlrc_pkg::TMR_OFF, 0); check("timer clr", r, 0);
    end
    swi_executed <= 1'b1; @(posedge pclk); swi_executed <= 1'b0;
    wait_hi(vector_fetch, 5);
    check("swi vector", vector_addr, srlrc_pkg::SWI_VEC);
    apb(1, srlrc_pkg::PWR_ONE_OFF, 8'h09); supply_below_low <= 1'b1;
    wait_hi(irq_request, 10);
    check("mon vector", irq_vector, srlrc_pkg::MON_VEC);
    check("no reset", system_reset, 1'b0);
    supply_below_low <= 1'b0; warn_below_low <= 1'b1;
    apb(1, srlrc_pkg::PWR_ONE_OFF, 8'h53);
    apb(0, srlrc_pkg::PWR_ONE_OFF, 0); check("warn held", r, 8'h83);
    warn_below_low <= 1'b0;
    apb(1, srlrc_pkg::PWR_ONE_OFF, 8'h43);
    apb(0, srlrc_pkg::PWR_ONE_OFF, 0); check("warn ack", r, 8'h03);
    stop_deep <= 1'b1; stop_enter <= 1'b1; @(posedge pclk);
    stop_enter <= 1'b0;
    wait_hi(stop_refused, 3); check("refused", stop_refused, 1'b1);
    check("no deep", deepest_stop_mode, 1'b0);
    apb(1, srlrc_pkg::OPT_OFF, 8'h10);
    stop_deep <= 1'b0; stop_enter <= 1'b1; @(posedge pclk);
    stop_enter <= 1'b0;
    wait_hi(light_stop_mode, 3); check("light", light_stop_mode, 1'b1);
    check("mon kept", supply_monitor_active, 1'b1);
    keypad_wake_input <= 4'h1;
    wait_hi(run_mode, 5); check("keypad wake", run_mode, 1'b1);
    keypad_wake_input <= 4'h0; stop_deep <= 1'b1;
    apb(1, srlrc_pkg::PWR_ONE_OFF, 8'h01);
    stop_enter <= 1'b1; @(posedge pclk); stop_enter <= 1'b0;
    wait_hi(deepest_stop_mode, 3);
    check("deep", deepest_stop_mode, 1'b1);
    check("mon off", supply_monitor_active, 1'b0);
    keypad_wake_input <= 4'h1; stop_deep <= 1'b0;
    wait_hi(vector_fetch, 10);
    check("deep wake", vector_addr, srlrc_pkg::RESET_VEC);
    apb(1, srlrc_pkg::OPT_OFF, 8'h04); temp_below_restart <= 1'b1;
    @(posedge pclk); temp_below_restart <= 1'b0;
    wait_hi(vector_fetch, 10);
    apb(0, srlrc_pkg::CAUSE_OFF, 0);
    check("temp cause", r, 1 << srlrc_pkg::C_TEMP_BIT);
    apb(1, srlrc_pkg::PWR_THREE_OFF, 8'h01);
    apb(1, srlrc_pkg::PWR_ONE_OFF, 8'h05); supply_below_high <= 1'b1;
    repeat (4) @(posedge pclk);
    check("mon reset", system_reset, 1'b1);
    supply_below_high <= 1'b0;
    wait_hi(vector_fetch, 10);
    apb(0, srlrc_pkg::CAUSE_OFF, 0);
    check("mon cause", r, 1 << srlrc_pkg::C_MON_BIT);
    check("fetches", fetch_count, 8'd9);
    complete_run;
  end
endmodule
`default_nettype wire
